//--- src/eip_pkg.sv
// Constants, field layouts and types for the external interrupt pins.
// Assumes an APB master on the system bus clock and active low pins.
// Operation
// - Software picks falling edge or low level triggering for the maskable pin.
// - After reset the maskable pin is enabled and set to level triggering.
// - Clearing the maskable enable stops all requests from that pin.
// - Reset sets the maskable mask so pin requests wait until unmasked.
// - Reset sets the non-maskable mask, which only software may clear.
// - The non-maskable pin is seen by its low level, never by an edge.
// - Both request pins are inputs only and their levels are always readable.
// - Pull-ups are on in and right after reset until software clears them.
// - A keypad pin set as input can raise a wakeup from stop or wait.
package eip_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PULL = 8'h04;
    localparam logic [7:0] OFF_COND = 8'h08;
    localparam logic [7:0] OFF_PORTE = 8'h0c;
    localparam logic [7:0] OFF_KW_DIR = 8'h10;
    localparam logic [7:0] OFF_KW_EN = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1c;
    localparam logic [7:0] OFF_KW_FLAG = 8'h20;
    localparam int KW_WIDTH_DEF = 8;
    localparam int KW_WIDTH_MAX = 32;

    // Control word, bit 1 edge select, bit 0 enable
    typedef struct packed {
        logic edge_mode;
        logic maskable_request_enable;
    } eip_ctrl_type;
    localparam eip_ctrl_type CTRL_RESET = '{edge_mode: 1'b0,
        maskable_request_enable: 1'b1};

    // Condition code masks, bit 1 non-maskable, bit 0 maskable
    typedef struct packed {
        logic x_mask;
        logic i_mask;
    } eip_cond_type;
    localparam eip_cond_type COND_RESET = '{x_mask: 1'b1, i_mask: 1'b1};

    // Sticky events, bit 2 keypad, bit 1 non-maskable, bit 0 maskable
    typedef struct packed {
        logic keypad;
        logic nonmaskable;
        logic maskable;
    } eip_event_type;
    localparam int EVT_W = 3;
    localparam eip_event_type EVT_NONE = '{keypad: 1'b0,
        nonmaskable: 1'b0, maskable: 1'b0};

    localparam logic PULLUP_RESET = 1'b1;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_DONE = 1'b1
    } eip_apb_state_type;
endpackage

//--- src/eip_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes pins idle at the reset level given by RST_VAL.
`timescale 1ns/1ps
`default_nettype none
module eip_sync #(
    parameter int WIDTH = 1,
    parameter logic RST_VAL = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= {WIDTH{RST_VAL}};
            sync_reg <= {WIDTH{RST_VAL}};
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule // eip_sync
`default_nettype wire

//--- src/eip_top.sv
// External interrupt pin conditioning with an APB register slave.
// Assumes pins are asynchronous and the CPU pulses irq_ack_i on service.
`timescale 1ns/1ps
`default_nettype none
module eip_top #(
    parameter int KW_WIDTH = eip_pkg::KW_WIDTH_DEF
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [eip_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [eip_pkg::DATA_W-1:0] pwdata_i,
    output logic [eip_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic maskable_request_pin_b_i,
    input wire logic nonmaskable_request_pin_b_i,
    input wire logic [KW_WIDTH-1:0] keypad_wakeup_input_i,
    input wire logic irq_ack_i,
    output logic maskable_irq_o,
    output logic nonmaskable_irq_o,
    output logic wakeup_o,
    output logic int_o,
    output logic pullup_en_o
);
    generate
        if (KW_WIDTH < 1 || KW_WIDTH > eip_pkg::KW_WIDTH_MAX) begin : g_chk
            $error("KW_WIDTH out of range");
        end
    endgenerate

    eip_pkg::eip_apb_state_type apb_state_reg;
    eip_pkg::eip_apb_state_type apb_state_next;
    eip_pkg::eip_ctrl_type ctrl_reg;
    eip_pkg::eip_ctrl_type ctrl_next;
    eip_pkg::eip_cond_type cond_reg;
    eip_pkg::eip_cond_type cond_next;
    eip_pkg::eip_event_type status_reg;
    eip_pkg::eip_event_type status_next;
    eip_pkg::eip_event_type mask_reg;
    eip_pkg::eip_event_type mask_next;
    eip_pkg::eip_event_type evt;
    logic pull_reg;
    logic pull_next;
    logic [KW_WIDTH-1:0] kw_dir_reg;
    logic [KW_WIDTH-1:0] kw_en_reg;
    logic [KW_WIDTH-1:0] kw_flag_reg;
    logic [KW_WIDTH-1:0] kw_flag_next;
    logic [KW_WIDTH-1:0] kw_prev_reg;
    logic [KW_WIDTH-1:0] kw_lvl;
    logic [KW_WIDTH-1:0] kw_fall;
    logic [1:0] pin_lvl;
    logic irq_lvl;
    logic nmi_lvl;
    logic irq_prev_reg;
    logic irq_fall;
    logic pend_reg;
    logic pend_next;
    logic mi_reg;
    logic mi_next;
    logic nmi_reg;
    logic nmi_next;
    logic wake_reg;
    logic int_reg;
    logic first_reg;
    logic [eip_pkg::DATA_W-1:0] rd_data;
    logic [eip_pkg::DATA_W-1:0] prdata_reg;
    logic pslverr_reg;
    logic access;
    logic done;
    logic hit;
    logic wr;
    logic wr_ctrl;
    logic wr_pull;
    logic wr_cond;
    logic wr_kw_dir;
    logic wr_kw_en;
    logic wr_status;
    logic wr_mask;
    logic wr_kw_flag;

    // Pin synchronisers
    eip_sync #(
        .WIDTH(2),
        .RST_VAL(eip_pkg::PIN_IDLE)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .async_i({maskable_request_pin_b_i, nonmaskable_request_pin_b_i}),
        .sync_o(pin_lvl)
    );

    eip_sync #(
        .WIDTH(KW_WIDTH),
        .RST_VAL(eip_pkg::PIN_IDLE)
    ) u_kw_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(keypad_wakeup_input_i),
        .sync_o(kw_lvl)
    );

    assign irq_lvl = pin_lvl[1];
    assign nmi_lvl = pin_lvl[0];

    // Bus decode
    assign access = psel_i & penable_i;
    assign done = access & (apb_state_reg == eip_pkg::APB_DONE);
    assign hit = (paddr_i == eip_pkg::OFF_CTRL) |
        (paddr_i == eip_pkg::OFF_PULL) |
        (paddr_i == eip_pkg::OFF_COND) |
        (paddr_i == eip_pkg::OFF_PORTE) |
        (paddr_i == eip_pkg::OFF_KW_DIR) |
        (paddr_i == eip_pkg::OFF_KW_EN) |
        (paddr_i == eip_pkg::OFF_STATUS) |
        (paddr_i == eip_pkg::OFF_MASK) |
        (paddr_i == eip_pkg::OFF_KW_FLAG);
    assign wr = done & pwrite_i;
    assign wr_ctrl = wr & (paddr_i == eip_pkg::OFF_CTRL);
    assign wr_pull = wr & (paddr_i == eip_pkg::OFF_PULL);
    assign wr_cond = wr & (paddr_i == eip_pkg::OFF_COND);
    assign wr_kw_dir = wr & (paddr_i == eip_pkg::OFF_KW_DIR);
    assign wr_kw_en = wr & (paddr_i == eip_pkg::OFF_KW_EN);
    assign wr_status = wr & (paddr_i == eip_pkg::OFF_STATUS);
    assign wr_mask = wr & (paddr_i == eip_pkg::OFF_MASK);
    assign wr_kw_flag = wr & (paddr_i == eip_pkg::OFF_KW_FLAG);

    // Read mux, pin levels readable at any time
    assign rd_data =
        (paddr_i == eip_pkg::OFF_CTRL) ? {30'h0, ctrl_reg} :
        (paddr_i == eip_pkg::OFF_PULL) ? {31'h0, pull_reg} :
        (paddr_i == eip_pkg::OFF_COND) ? {30'h0, cond_reg} :
        (paddr_i == eip_pkg::OFF_PORTE) ? {30'h0, irq_lvl, nmi_lvl} :
        (paddr_i == eip_pkg::OFF_KW_DIR) ?
            eip_pkg::DATA_W'(kw_dir_reg) :
        (paddr_i == eip_pkg::OFF_KW_EN) ?
            eip_pkg::DATA_W'(kw_en_reg) :
        (paddr_i == eip_pkg::OFF_STATUS) ? {29'h0, status_reg} :
        (paddr_i == eip_pkg::OFF_MASK) ? {29'h0, mask_reg} :
        (paddr_i == eip_pkg::OFF_KW_FLAG) ?
            eip_pkg::DATA_W'(kw_flag_reg) :
        eip_pkg::DATA_ZERO;

    // Register next values
    assign ctrl_next = wr_ctrl ?
        eip_pkg::eip_ctrl_type'(pwdata_i[1:0]) : ctrl_reg;
    assign pull_next = wr_pull ? pwdata_i[0] : pull_reg;
    // Non-maskable mask can only be cleared by software
    assign cond_next.i_mask = wr_cond ? pwdata_i[0] : cond_reg.i_mask;
    assign cond_next.x_mask = cond_reg.x_mask &
        ~(wr_cond & ~pwdata_i[1]);
    assign mask_next = wr_mask ?
        eip_pkg::eip_event_type'(pwdata_i[2:0]) : mask_reg;

    // Maskable pin, edge pending held until service
    assign irq_fall = irq_prev_reg & ~irq_lvl;
    assign pend_next = ctrl_reg.maskable_request_enable &
        ctrl_reg.edge_mode &
        (irq_fall | (pend_reg & ~irq_ack_i));
    assign mi_next = ctrl_reg.maskable_request_enable &
        ~cond_reg.i_mask &
        (ctrl_reg.edge_mode ? pend_reg : ~irq_lvl);
    // Non-maskable pin is level only
    assign nmi_next = ~cond_reg.x_mask & ~nmi_lvl;

    // Keypad falling edges on pins set as inputs
    assign kw_fall = kw_prev_reg & ~kw_lvl & kw_en_reg &
        ~kw_dir_reg;
    assign kw_flag_next = kw_fall |
        (kw_flag_reg & ~(wr_kw_flag ? pwdata_i[KW_WIDTH-1:0] :
        {KW_WIDTH{1'b0}}));

    // Sticky status, a new event beats a clear
    assign evt.keypad = |kw_fall;
    assign evt.nonmaskable = nmi_next & ~nmi_reg;
    assign evt.maskable = mi_next & ~mi_reg;
    assign status_next = evt | (status_reg &
        ~(wr_status ? eip_pkg::eip_event_type'(pwdata_i[2:0]) :
        eip_pkg::EVT_NONE));

    assign apb_state_next = (apb_state_reg == eip_pkg::APB_IDLE) ?
        (access ? eip_pkg::APB_DONE : eip_pkg::APB_IDLE) :
        eip_pkg::APB_IDLE;

    // Bus answer
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            apb_state_reg <= eip_pkg::APB_IDLE;
            prdata_reg <= eip_pkg::DATA_ZERO;
            pslverr_reg <= 1'b0;
        end else begin
            apb_state_reg <= apb_state_next;
            if (access && apb_state_reg == eip_pkg::APB_IDLE) begin
                prdata_reg <= pwrite_i ? eip_pkg::DATA_ZERO : rd_data;
                pslverr_reg <= ~hit;
            end
        end
    end

    // Software registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_reg <= eip_pkg::CTRL_RESET;
            cond_reg <= eip_pkg::COND_RESET;
            pull_reg <= eip_pkg::PULLUP_RESET;
            mask_reg <= eip_pkg::EVT_NONE;
            kw_dir_reg <= {KW_WIDTH{1'b0}};
            kw_en_reg <= {KW_WIDTH{1'b0}};
        end else begin
            ctrl_reg <= ctrl_next;
            cond_reg <= cond_next;
            pull_reg <= pull_next;
            mask_reg <= mask_next;
            if (wr_kw_dir) begin
                kw_dir_reg <= pwdata_i[KW_WIDTH-1:0];
            end
            if (wr_kw_en) begin
                kw_en_reg <= pwdata_i[KW_WIDTH-1:0];
            end
        end
    end

    // Pin state and request outputs
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_prev_reg <= eip_pkg::PIN_IDLE;
            kw_prev_reg <= {KW_WIDTH{eip_pkg::PIN_IDLE}};
            pend_reg <= 1'b0;
            mi_reg <= 1'b0;
            nmi_reg <= 1'b0;
            kw_flag_reg <= {KW_WIDTH{1'b0}};
            wake_reg <= 1'b0;
            status_reg <= eip_pkg::EVT_NONE;
            int_reg <= 1'b0;
            first_reg <= 1'b1;
        end else begin
            irq_prev_reg <= irq_lvl;
            kw_prev_reg <= kw_lvl;
            pend_reg <= pend_next;
            mi_reg <= mi_next;
            nmi_reg <= nmi_next;
            kw_flag_reg <= kw_flag_next;
            wake_reg <= |kw_flag_reg;
            status_reg <= status_next;
            int_reg <= |(status_reg & mask_reg);
            first_reg <= 1'b0;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = (apb_state_reg == eip_pkg::APB_DONE);
    assign pslverr_o = pslverr_reg;
    assign maskable_irq_o = mi_reg;
    assign nonmaskable_irq_o = nmi_reg;
    assign wakeup_o = wake_reg;
    assign int_o = int_reg;
    assign pullup_en_o = pull_reg;

    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_edge_mode_latch: assert property (
        (irq_fall && ctrl_reg.edge_mode &&
            ctrl_reg.maskable_request_enable)
        |=> pend_reg and ((ctrl_reg.maskable_request_enable &&
            ctrl_reg.edge_mode && !cond_reg.i_mask) |=> maskable_irq_o))
        else $error("falling edge not latched");

    a_reset_defaults: assert property (
        first_reg |-> ctrl_reg.maskable_request_enable &&
            !ctrl_reg.edge_mode)
        else $error("control not at reset default");

    a_disable_stops: assert property (
        !ctrl_reg.maskable_request_enable |=> !maskable_irq_o && !pend_reg)
        else $error("request while disabled");

    a_i_mask_block: assert property (
        (first_reg |-> cond_reg.i_mask) and
        (cond_reg.i_mask |=> !maskable_irq_o))
        else $error("maskable request while masked");

    a_x_mask_hold: assert property (
        (cond_reg.x_mask |=> !nonmaskable_irq_o) and
        (!cond_reg.x_mask |=> !cond_reg.x_mask))
        else $error("non-maskable mask misbehaves");

    a_nmi_level: assert property (
        (!cond_reg.x_mask && !nmi_lvl)[*3] |=> nonmaskable_irq_o [*1])
        else $error("low level not seen");

    a_port_readback: assert property (
        (access && !pwrite_i && apb_state_reg == eip_pkg::APB_IDLE &&
            paddr_i == eip_pkg::OFF_PORTE)
        |=> pready_o && prdata_o[1:0] == $past(pin_lvl))
        else $error("pin levels not read back");

    a_pullup_clear: assert property (
        (first_reg |-> pullup_en_o) and
        ($fell(pullup_en_o) |-> $past(wr_pull)))
        else $error("pull-up changed without write");

    a_keypad_wake: assert property (
        (|kw_fall) |=> ##1 wakeup_o)
        else $error("keypad edge gave no wakeup");

    a_pend_hold: assert property (
        (pend_reg && !irq_ack_i && ctrl_reg.edge_mode &&
            ctrl_reg.maskable_request_enable) |=> pend_reg)
        else $error("pending edge lost");

    a_int_level: assert property (
        (|(status_reg & mask_reg)) |=> int_o)
        else $error("interrupt output missing");

    a_pready_single: assert property (
        pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");

    a_unmapped_error: assert property (
        (access && apb_state_reg == eip_pkg::APB_IDLE && !hit)
        |=> pready_o && pslverr_o && prdata_o == eip_pkg::DATA_ZERO)
        else $error("unmapped access not refused");

    a_status_sticky: assert property (
        !wr_status
        |=> (~status_reg & $past(status_reg)) == eip_pkg::EVT_NONE)
        else $error("status bit lost without clear");

    a_event_beats_clear: assert property (
        ((|evt) && wr_status)
        |=> (status_reg & $past(evt)) == $past(evt))
        else $error("clear overrode a new event");

    a_pend_ack_clear: assert property (
        (pend_reg && irq_ack_i && !irq_fall) |=> !pend_reg)
        else $error("pending edge kept after service");

    a_wake_level: assert property (
        (|kw_flag_reg) |=> wakeup_o)
        else $error("wakeup missing while flag set");
endmodule // eip_top
`default_nettype wire

//--- verif/eip_src.sv
// Model of the external request sources and keypad switches.
// Assumes open-drain sources and the pull-up enable from the block.
`timescale 1ns/1ps
`default_nettype none
module eip_src #(
    parameter int KW = 8
) (
    input wire logic ref_clk_i,
    input wire logic pull_i,
    input wire logic [1:0] irq_low_i,
    input wire logic [1:0] nmi_low_i,
    input wire logic [KW-1:0] key_low_i,
    output logic irq_b_o,
    output logic nmi_b_o,
    output logic [KW-1:0] key_b_o
);
    logic float_reg = 1'h0;
    // Undriven line without pull-up wanders every cycle
    always @(posedge ref_clk_i) begin
        float_reg <= ~float_reg;
    end
    // Open-drain sources share a line, held high by the pull-up
    assign irq_b_o = (|irq_low_i) ? 1'h0 :
        (pull_i ? 1'h1 : float_reg);
    assign nmi_b_o = (|nmi_low_i) ? 1'h0 :
        (pull_i ? 1'h1 : float_reg);
    // Keypad switches ground a line held high outside
    assign key_b_o = ~key_low_i;
endmodule // eip_src
`default_nettype wire

//--- verif/eip_top_tb.sv
// Self-checking bench for the external interrupt pin block.
// Assumes the package, design files and source model compile first.
`timescale 1ns/1ps
`default_nettype none
module eip_top_tb;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic er;
    } eip_row_type;
    logic ref_clk_i, rst_b_i = 1'h0, irq_ack_i = 1'h0;
    logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [7:0] paddr_i = 8'h0, key_low = 8'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, maskable_irq_o, nonmaskable_irq_o;
    logic wakeup_o, int_o, pullup_en_o, er;
    logic maskable_request_pin_b_i, nonmaskable_request_pin_b_i;
    logic [7:0] keypad_wakeup_input_i;
    logic [1:0] irq_low = 2'h0, nmi_low = 2'h0;
    int fail_count = 0;
    int checked = 0;
    eip_row_type rows [11] = '{
        '{1'h0, 8'h00, 32'h0, 32'h1, 1'h0},
        '{1'h0, 8'h04, 32'h0, 32'h1, 1'h0},
        '{1'h0, 8'h08, 32'h0, 32'h3, 1'h0},
        '{1'h0, 8'h0c, 32'h0, 32'h3, 1'h0},
        '{1'h0, 8'h18, 32'h0, 32'h0, 1'h0},
        '{1'h1, 8'h0c, 32'h0, 32'h0, 1'h0},
        '{1'h0, 8'h0c, 32'h0, 32'h3, 1'h0},
        '{1'h1, 8'h24, 32'hffffffff, 32'h0, 1'h1},
        '{1'h0, 8'h24, 32'h0, 32'h0, 1'h1},
        '{1'h1, 8'h1c, 32'hffffffff, 32'h0, 1'h0},
        '{1'h0, 8'h1c, 32'h0, 32'h7, 1'h0}};

    eip_top DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .maskable_request_pin_b_i(maskable_request_pin_b_i),
        .nonmaskable_request_pin_b_i(nonmaskable_request_pin_b_i),
        .keypad_wakeup_input_i(keypad_wakeup_input_i),
        .irq_ack_i(irq_ack_i), .maskable_irq_o(maskable_irq_o),
        .nonmaskable_irq_o(nonmaskable_irq_o), .wakeup_o(wakeup_o),
        .int_o(int_o), .pullup_en_o(pullup_en_o));
    eip_src SRC (.ref_clk_i(ref_clk_i), .pull_i(pullup_en_o),
        .irq_low_i(irq_low), .nmi_low_i(nmi_low), .key_low_i(key_low),
        .irq_b_o(maskable_request_pin_b_i),
        .nmi_b_o(nonmaskable_request_pin_b_i),
        .key_b_o(keypad_wakeup_input_i));

    initial begin
        ref_clk_i = 1'h0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic final_report();
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n = 0;
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        tick(1);
        penable_i <= 1'h1;
        do begin
            tick(1);
            n++;
        end while (pready_o !== 1'h1 && n < 50);
        if (pready_o !== 1'h1) begin
            fail_count++;
            final_report();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask

    initial begin
        tick(2);
        chk(pullup_en_o, 32'h1);
        rst_b_i <= 1'h1;
        tick(1);
        for (int i = 0; i < 11; i++) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                chk(rd, rows[i].e);
            chk(er, rows[i].er);
        end
        // Maskable pin, level mode
        irq_low <= 2'h1;
        tick(4);
        chk(maskable_irq_o, 32'h0);
        rdc(8'h0c, 32'h1);
        wr(8'h08, 32'h2);
        tick(3);
        chk(maskable_irq_o, 32'h1);
        chk(int_o, 32'h1);
        wr(8'h00, 32'h0);
        tick(2);
        chk(maskable_irq_o, 32'h0);
        rdc(8'h18, 32'h1);
        wr(8'h18, 32'h1);
        tick(2);
        chk(int_o, 32'h0);
        // Maskable pin, edge mode with pending until serviced
        irq_low <= 2'h0;
        wr(8'h00, 32'h3);
        tick(3);
        chk(maskable_irq_o, 32'h0);
        irq_low <= 2'h2;
        tick(3);
        irq_low <= 2'h0;
        tick(3);
        chk(maskable_irq_o, 32'h1);
        irq_ack_i <= 1'h1;
        tick(1);
        irq_ack_i <= 1'h0;
        tick(2);
        chk(maskable_irq_o, 32'h0);
        // Non-maskable pin on a shared line
        nmi_low <= 2'h3;
        tick(4);
        chk(nonmaskable_irq_o, 32'h0);
        wr(8'h08, 32'h0);
        tick(2);
        chk(nonmaskable_irq_o, 32'h1);
        nmi_low <= 2'h1;
        tick(4);
        chk(nonmaskable_irq_o, 32'h1);
        nmi_low <= 2'h0;
        tick(4);
        chk(nonmaskable_irq_o, 32'h0);
        wr(8'h08, 32'h3);
        rdc(8'h08, 32'h1);
        // Keypad wakeup, output pin never flags
        wr(8'h14, 32'h3);
        wr(8'h10, 32'h2);
        key_low <= 8'h3;
        tick(5);
        chk(wakeup_o, 32'h1);
        rdc(8'h20, 32'h1);
        rdc(8'h18, 32'h7);
        wr(8'h20, 32'h1);
        tick(2);
        chk(wakeup_o, 32'h0);
        key_low <= 8'h0;
        // Pull-ups off, then back on through a second reset
        wr(8'h04, 32'h0);
        chk(pullup_en_o, 32'h0);
        rst_b_i <= 1'h0;
        tick(1);
        chk(pullup_en_o, 32'h1);
        rst_b_i <= 1'h1;
        tick(2);
        rdc(8'h08, 32'h3);
        rdc(8'h00, 32'h1);
        final_report();
    end
endmodule // eip_top_tb
`default_nettype wire
